// >>> ssd_deserializer.v
// start-stop character deserializer with apb registers and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "ssd_defs.vh"
module ssd_deserializer #(
    parameter [15:0] BIT_CYC = `SSD_BIT_CYC,
    parameter [15:0] CLR_CYC = `SSD_CLR_CYC
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // serial line, mark high
    input wire line_in,
    // auxiliary equipment
    input wire osc_enable_in,
    input wire blind_in,
    // to the receiving signal converter
    output reg [7:0] parallel_data,
    output reg xfer_pulse,
    output reg clear_pulse,
    output reg aux_done_pulse,
    // interrupt
    output reg irq
);
    localparam [15:0] XFER_CYC = `SSD_XFER_CYC;
    localparam [15:0] GLITCH_CYC = `SSD_GLITCH_CYC;
    localparam [15:0] HALF_CYC = {1'b0, BIT_CYC[15:1]};

    // entry stage index for a level code: 0..3 means 8..5 levels
    function [2:0] entry_idx;
        input [1:0] code;
        begin
            entry_idx = 3'h7 - {1'b0, code};
        end
    endfunction

    reg [2:0] ctrl_q;
    reg [`SSD_INT_W-1:0] int_stat_q;
    reg [`SSD_INT_W-1:0] int_mask_q;
    reg [7:0] data_q;
    reg framing_control_flop_q;
    reg [7:0] sreg_q;
    reg [15:0] osc_cnt_q;
    reg resync_flop_q;
    reg [15:0] low_cnt_q;
    reg gated_prev_q;
    wire line_s;
    wire osc_en_s;
    wire blind_s;
    wire test_mode;
    wire [2:0] entry;
    wire line_open;
    wire gated;
    wire prime_one_input;
    wire prime_zero_input;
    wire osc_run;
    wire adv;
    wire flag_fall;
    wire fall;
    wire start_ok;
    wire start_accept_gate;
    wire hb_busy;
    wire hb_done;
    wire xt_busy;
    wire xt_done;
    wire ct_busy;
    wire ct_done;
    wire sf_busy;
    wire sf_done;
    wire apb_setup;
    wire apb_access;
    wire [`SSD_INT_W-1:0] int_set;
    reg [31:0] rd_mux;
    reg rd_ok;
    integer i;

    assign test_mode = ctrl_q[`SSD_CTRL_TEST];
    assign entry = entry_idx(ctrl_q[`SSD_CTRL_LVL_HI:`SSD_CTRL_LVL_LO]);

    // pins cross in through two flops; line and oscillator enable idle high, blind idles low
    ssd_sync #(
        .W(3),
        .RST(3'h3)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({blind_in, osc_enable_in, line_in}),
        .q({blind_s, osc_en_s, line_s})
    );

    // input gate: idle while in test or blinded
    assign line_open = (test_mode | blind_s) ? 1'b1 : line_s;
    // test feeds locally made blanks: mark during stop-fill, space after
    assign gated = test_mode ? sf_busy : (resync_flop_q ? line_open : 1'b1);

    // complementary prime pair into the entry stage
    assign prime_one_input = gated;
    assign prime_zero_input = ~gated;

    // bit_rate_oscillator
    assign osc_run = framing_control_flop_q & osc_en_s;
    assign adv = osc_run & (osc_cnt_q == BIT_CYC - 16'h0001);
    assign flag_fall = adv & ~sreg_q[0];

    // start validation
    assign fall = gated_prev_q & ~gated;
    assign start_accept_gate = ~framing_control_flop_q;
    // line must stay low past the 40 us sample and the half bit
    assign start_ok = hb_done & start_accept_gate & ~gated & (low_cnt_q >= GLITCH_CYC)
        & (low_cnt_q >= HALF_CYC - 16'h0002);

    // half_bit_timer runs only while the oscillator is idle
    ssd_oneshot u_half_bit_timer (
        .pclk(pclk),
        .presetn(presetn),
        .trig(fall & start_accept_gate),
        .len(HALF_CYC),
        .busy(hb_busy),
        .done(hb_done)
    );

    // transfer_timer
    ssd_oneshot u_transfer_timer (
        .pclk(pclk),
        .presetn(presetn),
        .trig(flag_fall),
        .len(XFER_CYC),
        .busy(xt_busy),
        .done(xt_done)
    );

    // clear_timer, always later than the transfer
    ssd_oneshot u_clear_timer (
        .pclk(pclk),
        .presetn(presetn),
        .trig(flag_fall),
        .len(CLR_CYC),
        .busy(ct_busy),
        .done(ct_done)
    );

    // stop_fill_timer lasts one bit, like a stop element
    ssd_oneshot u_stop_fill_timer (
        .pclk(pclk),
        .presetn(presetn),
        .trig(flag_fall),
        .len(BIT_CYC),
        .busy(sf_busy),
        .done(sf_done)
    );

    // oscillator counter; after a start the first advance comes next cycle
    // so that the start element itself is shifted in
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt_q <= 16'h0000;
        end else if (start_ok) begin
            osc_cnt_q <= BIT_CYC - 16'h0001;
        end else if (osc_run) begin
            if (adv) begin
                osc_cnt_q <= 16'h0000;
            end else begin
                osc_cnt_q <= osc_cnt_q + 16'h0001;
            end
        end else if (!framing_control_flop_q) begin
            osc_cnt_q <= 16'h0000;
        end
    end

    // framing_control_flop: set at power-up so one advance flushes the register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            framing_control_flop_q <= 1'b1;
        end else if (start_ok) begin
            framing_control_flop_q <= 1'b1;
        end else if (adv) begin
            framing_control_flop_q <= sreg_q[0];
        end
    end

    // shift register, stage 0 sits next to the flag
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sreg_q <= `SSD_SREG_RST;
        end else if (ct_done) begin
            sreg_q <= `SSD_SREG_ONES;
        end else if (adv) begin
            for (i = 0; i < 8; i = i + 1) begin
                if (i == entry) begin
                    sreg_q[i] <= prime_one_input & ~prime_zero_input;
                end else if (i < entry) begin
                    sreg_q[i] <= sreg_q[i + 1];
                end else begin
                    sreg_q[i] <= 1'b1;
                end
            end
        end
    end

    // resync_flop: held at zero during stop-fill, never reopened in test
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resync_flop_q <= 1'b0;
        end else if (sf_busy || test_mode) begin
            resync_flop_q <= 1'b0;
        end else if (sf_done) begin
            resync_flop_q <= 1'b1;
        end
    end

    // low-time counter for glitch rejection
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt_q <= 16'h0000;
            gated_prev_q <= 1'b1;
        end else begin
            gated_prev_q <= gated;
            if (gated) begin
                low_cnt_q <= 16'h0000;
            end else if (low_cnt_q != 16'hFFFF) begin
                low_cnt_q <= low_cnt_q + 16'h0001;
            end
        end
    end

    // converter outputs; inhibit of punching is the converter's business
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            parallel_data <= `SSD_SREG_ONES;
            xfer_pulse <= 1'b0;
            clear_pulse <= 1'b0;
            aux_done_pulse <= 1'b0;
            data_q <= 8'h00;
        end else begin
            parallel_data <= sreg_q;
            xfer_pulse <= xt_done;
            clear_pulse <= ct_done;
            aux_done_pulse <= ct_done;
            if (xt_done) begin
                data_q <= sreg_q;
            end
        end
    end

    // interrupt events: character transferred, start rejected as glitch
    assign int_set[`SSD_INT_CHAR] = xt_done;
    assign int_set[`SSD_INT_FALSE] = hb_done & start_accept_gate & ~start_ok;

    assign apb_setup = psel & ~penable;
    assign apb_access = psel & penable & pready;

    // read mux, unmapped addresses answer with an error
    always @* begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b1;
        case (paddr)
            `SSD_OFF_CTRL: begin
                rd_mux[2:0] = ctrl_q;
            end
            `SSD_OFF_STATUS: begin
                rd_mux[`SSD_ST_FLAG] = framing_control_flop_q;
                rd_mux[`SSD_ST_OSC] = osc_run;
                rd_mux[`SSD_ST_RESYNC] = resync_flop_q;
                rd_mux[`SSD_ST_BUSY] = xt_busy | ct_busy | hb_busy;
                rd_mux[15:8] = sreg_q;
            end
            `SSD_OFF_INT_STAT: begin
                rd_mux[`SSD_INT_W-1:0] = int_stat_q;
            end
            `SSD_OFF_INT_MASK: begin
                rd_mux[`SSD_INT_W-1:0] = int_mask_q;
            end
            `SSD_OFF_DATA: begin
                rd_mux[7:0] = data_q;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    // apb: data latched in setup, one access cycle with pready high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            prdata <= pwrite ? 32'h00000000 : rd_mux;
            pready <= 1'b1;
            pslverr <= ~rd_ok;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // register writes at the completing edge only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `SSD_CTRL_RST;
            int_mask_q <= {`SSD_INT_W{1'b0}};
        end else if (apb_access && pwrite) begin
            if (paddr == `SSD_OFF_CTRL) begin
                ctrl_q <= pwdata[2:0];
            end
            if (paddr == `SSD_OFF_INT_MASK) begin
                int_mask_q <= pwdata[`SSD_INT_W-1:0];
            end
        end
    end

    // sticky status, cleared by its read; a new event beats the clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_q <= {`SSD_INT_W{1'b0}};
            irq <= 1'b0;
        end else begin
            // clear only the bits that were read, so an event in the setup cycle survives
            if (apb_access && !pwrite && paddr == `SSD_OFF_INT_STAT) begin
                int_stat_q <= (int_stat_q & ~prdata[`SSD_INT_W-1:0]) | int_set;
            end else begin
                int_stat_q <= int_stat_q | int_set;
            end
            irq <= |((int_stat_q | int_set) & int_mask_q);
        end
    end
endmodule // ssd_deserializer
`default_nettype wire

// >>> ssd_defs.vh
// offsets, field positions, reset values and timing counts of the character deserializer
`ifndef SSD_DEFS_VH
`define SSD_DEFS_VH

// apb register byte offsets
`define SSD_OFF_CTRL 8'h00
`define SSD_OFF_STATUS 8'h04
`define SSD_OFF_INT_STAT 8'h08
`define SSD_OFF_INT_MASK 8'h0C
`define SSD_OFF_DATA 8'h10

// control register fields
`define SSD_CTRL_TEST 0
`define SSD_CTRL_LVL_LO 1
`define SSD_CTRL_LVL_HI 2
`define SSD_CTRL_RST 3'h0

// status register fields
`define SSD_ST_FLAG 0
`define SSD_ST_OSC 1
`define SSD_ST_RESYNC 2
`define SSD_ST_BUSY 3

// interrupt bits
`define SSD_INT_CHAR 0
`define SSD_INT_FALSE 1
`define SSD_INT_W 2

// shift register after power-up: stage next to the flag holds zero
`define SSD_SREG_RST 8'hFE
`define SSD_SREG_ONES 8'hFF

// timing, clock 25 MHz
`define SSD_CLK_MHZ 16'h0019
`define SSD_T_GLITCH_US 16'h0028
`define SSD_T_XFER_US 16'h0064
`define SSD_T_CLR_US 16'h00C8
`define SSD_GLITCH_CYC (`SSD_T_GLITCH_US * `SSD_CLK_MHZ)
`define SSD_XFER_CYC (`SSD_T_XFER_US * `SSD_CLK_MHZ)
`define SSD_CLR_CYC (`SSD_T_CLR_US * `SSD_CLK_MHZ)
// default bit period: 2400 bit/s at 25 MHz
`define SSD_BIT_CYC 16'h28B1

`endif

// >>> ssd_sync.v
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module ssd_sync #(
    parameter W = 1,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // data
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= RST;
            q <= RST;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // ssd_sync
`default_nettype wire

// >>> ssd_oneshot.v
// retriggerable one-shot timer counting system clocks
`timescale 1ns/1ps
`default_nettype none
module ssd_oneshot (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // trigger and length in cycles, at least one
    input wire trig,
    input wire [15:0] len,
    // timer state
    output reg busy,
    output reg done
);
    reg [15:0] cnt_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 16'h0000;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (trig) begin
                cnt_q <= len;
                busy <= 1'b1;
            end else if (busy) begin
                cnt_q <= cnt_q - 16'h0001;
                if (cnt_q <= 16'h0001) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule // ssd_oneshot
`default_nettype wire

// >>> ssd_deserializer_checker.sv
// concurrent checks on the deserializer ports
`timescale 1ns/1ps
`default_nettype none
`include "ssd_defs.vh"
module ssd_deserializer_checker #(
    parameter [15:0] CLR_CYC = `SSD_CLR_CYC
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    // converter side
    input wire [7:0] parallel_data,
    input wire xfer_pulse,
    input wire clear_pulse,
    input wire aux_done_pulse
);
    // cycles since the last transfer pulse, saturating so a stray clear fails
    logic [15:0] gap_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 16'hFFFF;
        end else if (xfer_pulse) begin
            gap_q <= 16'h0001;
        end else if (gap_q != 16'hFFFF) begin
            gap_q <= gap_q + 16'h0001;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_xfer;
        xfer_pulse ##1 !xfer_pulse;
    endsequence
    sequence s_setup;
        psel && !penable;
    endsequence

    property p_xfer_one;
        xfer_pulse |-> s_xfer;
    endproperty
    a_xfer_one: assert property (p_xfer_one) else $error("transfer pulse too long");
    property p_clr_gap;
        clear_pulse |-> gap_q == CLR_CYC - `SSD_XFER_CYC;
    endproperty
    a_clr_gap: assert property (p_clr_gap) else $error("clear not at fixed gap after transfer");
    property p_clr_ones;
        clear_pulse |-> ##[1:3] parallel_data == 8'hFF;
    endproperty
    a_clr_ones: assert property (p_clr_ones) else $error("stages not set after clear");
    property p_aux;
        clear_pulse == aux_done_pulse;
    endproperty
    a_aux: assert property (p_aux) else $error("aux pulse differs from clear");
    property p_hold_data;
        xfer_pulse |=> $stable(parallel_data)[*8];
    endproperty
    a_hold_data: assert property (p_hold_data) else $error("register moved after transfer");
    property p_apb_ready;
        s_setup |=> pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("no ready in access cycle");
    property p_ready_one;
        pready |=> !pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready held over one cycle");
    property p_err_ready;
        pslverr |-> pready && penable;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
endmodule // ssd_deserializer_checker

bind ssd_deserializer ssd_deserializer_checker #(.CLR_CYC(CLR_CYC)) i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .parallel_data(parallel_data),
    .xfer_pulse(xfer_pulse), .clear_pulse(clear_pulse), .aux_done_pulse(aux_done_pulse));
`default_nettype wire

// >>> ssd_converter_model.sv
// receiving converter model: storage register and punch count
`timescale 1ns/1ps
`default_nettype none
module ssd_converter_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // from the deserializer
    input wire logic [7:0] parallel_data,
    input wire logic xfer_pulse,
    input wire logic clear_pulse,
    // auxiliary punch inhibit
    input wire logic inhibit,
    // model state
    output logic [7:0] storage_q,
    output logic [7:0] punch_cnt_q
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            storage_q <= 8'h00;
            punch_cnt_q <= 8'h00;
        end else begin
            if (xfer_pulse) begin
                storage_q <= parallel_data;
            end
            // punch only when ready and not inhibited
            if (clear_pulse && !inhibit) begin
                punch_cnt_q <= punch_cnt_q + 8'h01;
            end
        end
    end
endmodule // ssd_converter_model
`default_nettype wire

// >>> tb_start_stop_char_deserializer.sv
// testbench for the start-stop character deserializer
`timescale 1ns/1ps
`default_nettype none
`include "ssd_defs.vh"
module tb_start_stop_char_deserializer;
    // half a bit must reach the glitch filter; kept short so the run stays small
    localparam [15:0] BIT = 16'h07D0;
    localparam [15:0] CLR = 16'h0A28;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic line_in = 1'b1;
    logic blind_in = 1'b0;
    logic osc_en = 1'b1;
    logic inhibit = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, xfer_pulse, clear_pulse, aux_done, irq;
    wire [7:0] parallel_data, storage, punch_cnt;
    int failures = 0;
    int n_compared = 0;
    int n_aux = 0;
    logic [31:0] rd;
    logic err;
    // level code, data sent, character expected
    logic [17:0] rows [4] = '{{2'h0, 8'hA5, 8'hA5}, {2'h1, 8'h5A, 8'hDA}, {2'h2, 8'h2C, 8'hEC}, {2'h3, 8'h13, 8'hF3}};

    always #20 pclk = ~pclk;

    // auxiliary pulses counted apart from the punch
    always @(posedge pclk) begin
        if (aux_done === 1'b1) begin
            n_aux++;
        end
    end

    ssd_deserializer #(.BIT_CYC(BIT), .CLR_CYC(CLR)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_in(line_in), .osc_enable_in(osc_en), .blind_in(blind_in),
        .parallel_data(parallel_data), .xfer_pulse(xfer_pulse), .clear_pulse(clear_pulse),
        .aux_done_pulse(aux_done), .irq(irq));
    ssd_converter_model i_conv (.pclk(pclk), .presetn(presetn), .parallel_data(parallel_data),
        .xfer_pulse(xfer_pulse), .clear_pulse(clear_pulse), .inhibit(inhibit), .storage_q(storage),
        .punch_cnt_q(punch_cnt));

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // start bit then n data bits, lsb first, line back to mark
    task automatic send(input logic [7:0] d, input int n);
        line_in <= 1'b0;
        repeat (BIT) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            line_in <= d[i];
            repeat (BIT) @(posedge pclk);
        end
        line_in <= 1'b1;
    endtask

    task automatic wait_clear(input int lim);
        int i;
        i = 0;
        while (clear_pulse !== 1'b1 && i < lim) begin
            @(posedge pclk);
            i++;
        end
        chk("clear_seen", i < lim, 1);
        @(posedge pclk);
    endtask

    task automatic finish_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        failures++;
        finish_test;
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `SSD_OFF_CTRL, 0);
        chk("ctrl_rst", rd, 0);
        apb(0, 8'h20, 0);
        chk("slverr", err, 1);
        wait_clear(6000);
        chk("punch_pwr", punch_cnt, 1);
        apb(0, `SSD_OFF_INT_STAT, 0);
        chk("int_pwr", rd, 1);
        apb(1, `SSD_OFF_INT_MASK, 1);
        for (int k = 0; k < 4; k++) begin
            apb(1, `SSD_OFF_CTRL, {29'h0, rows[k][17:16], 1'b0});
            send(rows[k][15:8], 8 - rows[k][17:16]);
            wait_clear(4000);
            chk("storage", storage, rows[k][7:0]);
            chk("cleared", parallel_data, 8'hFF);
            chk("punch", punch_cnt, k + 2);
            chk("irq_set", irq, 1);
            apb(0, `SSD_OFF_DATA, 0);
            chk("data", rd, rows[k][7:0]);
            apb(0, `SSD_OFF_INT_STAT, 0);
            chk("int_char", rd, 1);
            repeat (2) @(posedge pclk);
            chk("irq_clr", irq, 0);
        end
        // full-length start while blinded must leave no trace
        blind_in <= 1'b1;
        send(8'h00, 0);
        repeat (BIT) @(posedge pclk);
        blind_in <= 1'b0;
        // short glitch: false start, masked so irq stays low
        line_in <= 1'b0;
        repeat (500) @(posedge pclk);
        line_in <= 1'b1;
        repeat (BIT) @(posedge pclk);
        chk("irq_mask", irq, 0);
        chk("punch_none", punch_cnt, 5);
        apb(0, `SSD_OFF_INT_STAT, 0);
        chk("int_false", rd, 2);
        // aux lead holds the oscillator: start taken, no advance
        osc_en <= 1'b0;
        line_in <= 1'b0;
        repeat (BIT) @(posedge pclk);
        apb(0, `SSD_OFF_STATUS, 0);
        chk("osc_hold", rd[1:0], 1);
        // test mode, 5 levels: local spaces fill the held character, line left low
        apb(1, `SSD_OFF_CTRL, 7);
        inhibit <= 1'b1;
        osc_en <= 1'b1;
        wait_clear(14000);
        chk("test_char", storage, 8'hE0);
        chk("punch_inh", punch_cnt, 5);
        chk("aux_cnt", n_aux, 6);
        apb(0, `SSD_OFF_STATUS, 0);
        chk("resync_test", rd[`SSD_ST_RESYNC], 0);
        finish_test;
    end
endmodule // tb_start_stop_char_deserializer
`default_nettype wire
